// *** uart_status_flag_logic.sv ***
// status flag logic of the serial transmitter/receiver with its wishbone register slave
//
// Behaviour
// - empty-buffer flag set at reset and shifter load
// - empty-buffer flag cleared by seen-read, data write
// - complete flag set at reset and on entry to transmitter idle
// - complete flag cleared: data write, tx_on rise, break
// - full flag set when character enters data register
// - full flag cleared by seen-read, data read
// - idle set after 10 or 11 high bit times
// - idle count may start after start bit
// - idle count may start after stop bit
// - idle cleared by sequence, rearmed by new character
// - overrun set, new character and errors dropped
// - overrun cleared by seen-read, data read
// - seven/three sample voting sets noise with full
// - noise cleared by any status read, data read
// - framing error when stop bit samples low
// - framing error cleared by seen-read, data read
// - parity error when enabled parity mismatches
// - parity error cleared by status read, data read
// - status register read-only, writes ignored
`timescale 1ns/100ps
`include "uart_status_defines.svh"

module uart_status_flag_logic
   import uart_status_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        rxd_i,
   input  wire logic        bit_tick_i,
   input  wire rx_sample_t  rx_sample_i,
   input  wire logic        tx_load_i,
   input  wire logic        tx_busy_i,
   output ctrl_t            ctrl_o,
   output logic      [8:0]  tx_data_o,
   output logic             tx_buf_full_o
);

   // majority of three samples, or of seven in the start bit
   function automatic logic bit_value(input logic [6:0] s, input logic start);
      logic [2:0] ones;
      ones = 3'h0;
      if (start) begin
         for (int i = 0; i < 7; i++) begin
            ones = ones + {2'h0, s[i]};
         end
         bit_value = (ones > 3'h3);
      end else begin
         bit_value = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
      end
   endfunction : bit_value

   // any sample differing from the rest of its bit
   function automatic logic bit_noisy(input logic [6:0] s, input logic start);
      if (start) begin
         bit_noisy = (s != 7'h00) && (s != 7'h7f);
      end else begin
         bit_noisy = (s[2:0] != 3'h0) && (s[2:0] != 3'h7);
      end
   endfunction : bit_noisy

   logic [7:0] flags;
   logic [7:0] seen;
   ctrl_t      ctrl;
   logic [8:0] rx_buf;
   logic [8:0] rx_shift;
   logic       rx_par_acc;
   logic       rx_noise_acc;
   logic       idle_q;
   logic [3:0] idle_cnt;
   logic       idle_armed;
   logic       idle_allowed;

   logic       access;
   logic       stat_rd;
   logic       data_rd;
   logic       data_wr;
   logic       ctrl_wr;
   logic       ton_rise;
   logic       brk_wr;
   logic       smp_bit;
   logic       smp_noisy;
   logic       char_done;
   logic       char_noise;
   logic       char_frame;
   logic       char_parity;
   logic [8:0] char_data;
   logic       clr_full;
   logic       rx_accept;
   logic       overrun_evt;
   logic       tx_idle;
   logic       idle_evt;
   logic [3:0] char_time;

   // bus decode: a request is taken in the cycle before ack rises
   assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign stat_rd = access & ~wb_we_i & (wb_adr_i == `OFS_STATUS);
   assign data_rd = access & ~wb_we_i & (wb_adr_i == `OFS_DATA);
   assign data_wr = access & wb_we_i & (wb_adr_i == `OFS_DATA) & wb_sel_i[0];
   assign ctrl_wr = access & wb_we_i & (wb_adr_i == `OFS_CTRL) & wb_sel_i[0];
   assign ton_rise = ctrl_wr & wb_dat_i[`CTRL_TX_ON] & ~ctrl.tx_on;
   assign brk_wr   = ctrl_wr & wb_dat_i[`CTRL_SEND_BREAK];

   assign ctrl_o        = ctrl;
   assign tx_buf_full_o = ~flags[`FLAG_TX_EMPTY];

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // status is not a write target; unmapped reads give zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (access && !wb_we_i) begin
         unique case (wb_adr_i)
            `OFS_STATUS: wb_dat_o <= {24'h00_0000, flags};
            `OFS_DATA:   wb_dat_o <= {23'h00_0000, rx_buf};
            `OFS_CTRL:   wb_dat_o <= {26'h000_0000, ctrl};
            default:     wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl <= ctrl_t'(`CTRL_RESET);
      end else if (ctrl_wr) begin
         ctrl <= ctrl_t'(wb_dat_i[5:0]);
      end
   end

   // ninth bit keeps its old value unless its byte lane is written
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_data_o <= 9'h000;
      end else if (data_wr) begin
         tx_data_o <= {wb_sel_i[1] ? wb_dat_i[8] : tx_data_o[8], wb_dat_i[7:0]};
      end
   end

   // first half of each clearing sequence: remember what the status read showed; noise and parity are marked seen on any status read
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seen <= 8'h00;
      end else if (stat_rd) begin
         seen <= flags;
         seen[`FLAG_NOISE]  <= 1'b1;
         seen[`FLAG_PARITY] <= 1'b1;
      end else if (data_rd) begin
         seen[5:0] <= 6'h00;
      end else if (data_wr || ton_rise || brk_wr) begin
         seen[7:6] <= 2'h0;
      end
   end

   // receive frame assembly from the voted samples
   assign smp_bit   = bit_value(rx_sample_i.samples, rx_sample_i.is_start);
   assign smp_noisy = bit_noisy(rx_sample_i.samples, rx_sample_i.is_start);
   assign char_done   = rx_sample_i.valid & rx_sample_i.is_stop;
   assign char_noise  = rx_noise_acc | smp_noisy;
   assign char_frame  = ~smp_bit;
   assign char_parity = ctrl.parity_enable & (rx_par_acc != ctrl.parity_odd);
   assign char_data   = ctrl.char_len_select ? rx_shift : {1'b0, rx_shift[8:1]};

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_shift     <= 9'h000;
         rx_par_acc   <= 1'b0;
         rx_noise_acc <= 1'b0;
      end else if (rx_sample_i.valid && rx_sample_i.is_start) begin
         rx_shift     <= 9'h000;
         rx_par_acc   <= 1'b0;
         rx_noise_acc <= smp_noisy;
      end else if (rx_sample_i.valid && !rx_sample_i.is_stop) begin
         rx_shift     <= {smp_bit, rx_shift[8:1]};
         rx_par_acc   <= rx_par_acc ^ smp_bit;
         rx_noise_acc <= rx_noise_acc | smp_noisy;
      end
   end

   // a data read in the same cycle frees the register if the status read before it showed full, so no overrun then
   assign clr_full    = data_rd & seen[`FLAG_RX_FULL];
   assign rx_accept   = char_done & (~flags[`FLAG_RX_FULL] | clr_full);
   assign overrun_evt = char_done & flags[`FLAG_RX_FULL] & ~clr_full;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_buf <= 9'h000;
      end else if (rx_accept) begin
         rx_buf <= char_data;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_RX_FULL] <= 1'b0;
      end else if (rx_accept) begin
         flags[`FLAG_RX_FULL] <= 1'b1;
      end else if (clr_full) begin
         flags[`FLAG_RX_FULL] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_OVERRUN] <= 1'b0;
      end else if (overrun_evt) begin
         flags[`FLAG_OVERRUN] <= 1'b1;
      end else if (data_rd && seen[`FLAG_OVERRUN]) begin
         flags[`FLAG_OVERRUN] <= 1'b0;
      end
   end

   // error flags follow the character that sets the full flag; set beats clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_NOISE] <= 1'b0;
      end else if (rx_accept && char_noise) begin
         flags[`FLAG_NOISE] <= 1'b1;
      end else if (data_rd && seen[`FLAG_NOISE]) begin
         flags[`FLAG_NOISE] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_FRAMING] <= 1'b0;
      end else if (rx_accept && char_frame) begin
         flags[`FLAG_FRAMING] <= 1'b1;
      end else if (data_rd && seen[`FLAG_FRAMING]) begin
         flags[`FLAG_FRAMING] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_PARITY] <= 1'b0;
      end else if (rx_accept && char_parity) begin
         flags[`FLAG_PARITY] <= 1'b1;
      end else if (data_rd && seen[`FLAG_PARITY]) begin
         flags[`FLAG_PARITY] <= 1'b0;
      end
   end

   // idle detection: counts bit ticks while the line is high
   assign char_time = ctrl.char_len_select ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
   assign idle_evt  = idle_armed & rxd_i & bit_tick_i
                      & (idle_cnt == char_time - 4'h1);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_cnt   <= 4'h0;
         idle_armed <= 1'b0;
      end else if (rx_sample_i.valid && rx_sample_i.is_start) begin
         idle_cnt   <= 4'h0;
         idle_armed <= ~ctrl.idle_count_after_stop;
      end else if (rx_sample_i.valid && rx_sample_i.is_stop
                   && ctrl.idle_count_after_stop) begin
         idle_cnt   <= 4'h0;
         idle_armed <= 1'b1;
      end else if (!rxd_i) begin
         idle_cnt <= 4'h0;
      end else if (idle_evt) begin
         idle_cnt   <= 4'h0;
         idle_armed <= 1'b0;
      end else if (idle_armed && bit_tick_i) begin
         idle_cnt <= idle_cnt + 4'h1;
      end
   end

   // only one idle report per received character, however long the line rests
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_allowed <= 1'b0;
      end else if (rx_accept) begin
         idle_allowed <= 1'b1;
      end else if (idle_evt) begin
         idle_allowed <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_IDLE] <= 1'b0;
      end else if (idle_evt && idle_allowed) begin
         flags[`FLAG_IDLE] <= 1'b1;
      end else if (data_rd && seen[`FLAG_IDLE]) begin
         flags[`FLAG_IDLE] <= 1'b0;
      end
   end

   // transmit side
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_TX_EMPTY] <= 1'b1;
      end else if (tx_load_i) begin
         flags[`FLAG_TX_EMPTY] <= 1'b1;
      end else if (data_wr && seen[`FLAG_TX_EMPTY]) begin
         flags[`FLAG_TX_EMPTY] <= 1'b0;
      end
   end

   // completion is raised on the edge into idle so that a clearing action is not
   // overridden by a still-idle transmitter before it picks up the new work
   assign tx_idle = flags[`FLAG_TX_EMPTY] & ~tx_busy_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_q <= 1'b1;
      end else begin
         idle_q <= tx_idle;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags[`FLAG_TX_DONE] <= 1'b1;
      end else if (tx_idle && !idle_q) begin
         flags[`FLAG_TX_DONE] <= 1'b1;
      end else if (seen[`FLAG_TX_DONE] && (data_wr || ton_rise || brk_wr)) begin
         flags[`FLAG_TX_DONE] <= 1'b0;
      end
   end

endmodule : uart_status_flag_logic

// *** uart_status_defines.svh ***
// offsets, field positions, reset values and counts of the serial status flag block
`ifndef UART_STATUS_DEFINES_SVH
`define UART_STATUS_DEFINES_SVH

`define OFS_STATUS        8'h00
`define OFS_DATA          8'h04
`define OFS_CTRL          8'h08

`define FLAG_TX_EMPTY     7
`define FLAG_TX_DONE      6
`define FLAG_RX_FULL      5
`define FLAG_IDLE         4
`define FLAG_OVERRUN      3
`define FLAG_NOISE        2
`define FLAG_FRAMING      1
`define FLAG_PARITY       0

`define STATUS_RESET      8'hc0
`define CTRL_RESET        6'h00
`define CTRL_SEND_BREAK   5
`define CTRL_TX_ON        4

`define CHAR_BITS_SHORT   4'ha
`define CHAR_BITS_LONG    4'hb

`endif

// *** uart_status_pkg.sv ***
// types shared by the serial status flag block
package uart_status_pkg;

   typedef struct packed {
      logic send_break_ctl;
      logic tx_on;
      logic char_len_select;
      logic idle_count_after_stop;
      logic parity_odd;
      logic parity_enable;
   } ctrl_t;

   typedef struct packed {
      logic       valid;
      logic       is_start;
      logic       is_stop;
      logic [6:0] samples;
   } rx_sample_t;

endpackage : uart_status_pkg

// *** uart_status_flag_logic_sva.sv ***
// assertion checker bound to the serial status flag block
`timescale 1ns/100ps
`include "uart_status_defines.svh"

module uart_status_flag_logic_chk
   import uart_status_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rxd_i,
   input wire logic        bit_tick_i,
   input wire rx_sample_t  rx_sample_i,
   input wire logic        tx_load_i,
   input wire logic        tx_busy_i,
   input wire ctrl_t       ctrl_o,
   input wire logic [8:0]  tx_data_o,
   input wire logic        tx_buf_full_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic rq;
   logic wrq;
   assign rq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrq = rq && wb_we_i && wb_sel_i[0];

   a_ack_answer: assert property (rq |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:9] == 23'h0)
      else $error("upper read bits not zero");
   a_status_write_ignored: assert property (wrq && wb_adr_i == `OFS_STATUS && !tx_load_i
      |=> $stable(tx_buf_full_o) && $stable(ctrl_o))
      else $error("status write changed state");
   a_status_mirror: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `OFS_STATUS
      |-> wb_dat_o[`FLAG_TX_EMPTY] == !$past(tx_buf_full_o))
      else $error("status empty bit disagrees with buffer state");
   a_load_empties: assert property (tx_load_i |=> !tx_buf_full_o)
      else $error("shifter load did not free the buffer");
   a_data_buffered: assert property (wrq && wb_adr_i == `OFS_DATA
      |=> tx_data_o[7:0] == $past(wb_dat_i[7:0]))
      else $error("data write not buffered");
   a_ctrl_written: assert property (wrq && wb_adr_i == `OFS_CTRL
      |=> ctrl_o == $past(wb_dat_i[5:0]))
      else $error("control write not taken");
   a_reset_tx_empty: assert property ($rose(rstn_i) |-> !tx_buf_full_o && !wb_ack_o)
      else $error("buffer not empty after reset");
endmodule : uart_status_flag_logic_chk

bind uart_status_flag_logic uart_status_flag_logic_chk u_chk (.clk_i, .rstn_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i,
   .bit_tick_i, .rx_sample_i, .tx_load_i, .tx_busy_i, .ctrl_o, .tx_data_o, .tx_buf_full_o);

// *** serial_peer_model.sv ***
// remote serial transmitter with its bit-rate tick and sample stream
`timescale 1ns/100ps

module serial_peer_model
   import uart_status_pkg::*;
(
   input  wire logic clk_i,
   output logic      rxd_o,
   output logic      tick_o,
   output rx_sample_t smp_o
);
   logic [1:0] div = 2'h0;
   logic       act = 1'b0;
   logic       st  = 1'b0;
   logic       sp  = 1'b0;
   logic [6:0] sm  = 7'h7f;
   initial rxd_o = 1'b1;
   // tick runs free so idle time is counted between frames too
   assign tick_o = (div == 2'h3);
   assign smp_o  = {tick_o & act, st, sp, sm};
   always @(posedge clk_i) div <= div + 2'h1;

   // a bit is held for one tick period; nz flips one sample to fake noise
   task automatic bit_out(input logic b, input logic s0, input logic s1, input logic nz);
      @(posedge clk_i iff div == 2'h3);
      rxd_o <= b;
      act   <= 1'b1;
      st    <= s0;
      sp    <= s1;
      sm    <= {7{b}} ^ {6'h0, nz};
   endtask : bit_out

   task automatic frame(input logic [8:0] d, input logic nine, input logic nz, input logic fe);
      bit_out(1'b0, 1'b1, 1'b0, nz);
      for (int i = 0; i < (nine ? 9 : 8); i++) bit_out(d[i], 1'b0, 1'b0, 1'b0);
      bit_out(!fe, 1'b0, 1'b1, 1'b0);
      @(posedge clk_i iff div == 2'h3);
      act   <= 1'b0;
      rxd_o <= 1'b1;
   endtask : frame
endmodule : serial_peer_model

// *** tb_uart_status_flag_logic.sv ***
// self-checking testbench of the serial status flag block
`timescale 1ns/100ps
`include "uart_status_defines.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_uart_status_flag_logic
   import uart_status_pkg::*;
;
   logic        clk, rstn, cyc, stb, we, rxd, tick, tx_load, tx_busy, ack, tx_full;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [8:0]  txd;
   rx_sample_t  smp;
   ctrl_t       ctrl;
   int          num_errors = 0;
   int          total_checks = 0;

   uart_status_flag_logic DUT (.clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rxd_i(rxd), .bit_tick_i(tick), .rx_sample_i(smp), .tx_load_i(tx_load),
      .tx_busy_i(tx_busy), .ctrl_o(ctrl), .tx_data_o(txd), .tx_buf_full_o(tx_full));
   serial_peer_model peer (.clk_i(clk), .rxd_o(rxd), .tick_o(tick), .smp_o(smp));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finish_test;
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hf;
      // a slave that never answers is caught by the watchdog
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd

   // bit 8 of data depends on the character length, so only the low byte is compared
   task automatic rd_data(input logic [7:0] e);
      bus(1'b0, `OFS_DATA, 32'h0);
      `CHK(q[7:0], e)
   endtask : rd_data

   task automatic rx_case(input logic [7:0] c, input logic [8:0] d, input logic nz,
                          input logic fe, input logic ov, input logic [7:0] e);
      bus(1'b1, `OFS_CTRL, {24'h0, c});
      if (ov) peer.frame(9'h011, c[3], 1'b0, 1'b0);
      peer.frame(d, c[3], nz, fe);
      repeat (12) @(posedge clk);
      rd(`OFS_STATUS, {24'h0, e});
      repeat (60) @(posedge clk);
      rd(`OFS_STATUS, {24'h0, e | 8'h10});
      rd_data(ov ? 8'h11 : d[7:0]);
      rd(`OFS_STATUS, 32'hc0);
   endtask : rx_case

   // the run takes about 1300 cycles; the limit leaves ample margin
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   initial begin
      {rstn, cyc, stb, we, tx_load, tx_busy} = 6'h00;
      adr  = 8'h00;
      sel  = 4'h0;
      wdat = 32'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // a data write with no status read before it clears nothing
      bus(1'b1, `OFS_DATA, 32'h5a);
      rd(`OFS_STATUS, 32'hc0);
      rd(`OFS_STATUS, 32'hc0);
      `CHK(tx_full, 1'b0)
      bus(1'b1, `OFS_STATUS, 32'h0);
      rd(`OFS_STATUS, 32'hc0);
      rd(8'h10, 32'h0);
      bus(1'b1, `OFS_DATA, 32'h1a5);
      rd(`OFS_STATUS, 32'h0);
      `CHK(tx_full, 1'b1)
      `CHK(txd, 9'h1a5)
      tx_busy <= 1'b1;
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      @(posedge clk);
      rd(`OFS_STATUS, 32'h80);
      tx_busy <= 1'b0;
      repeat (2) @(posedge clk);
      rd(`OFS_STATUS, 32'hc0);
      // both control-side triggers: transmitter enable rise, then break request
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, `OFS_CTRL, 32'h0);
         tx_busy <= 1'b1;
         @(posedge clk);
         tx_busy <= 1'b0;
         repeat (2) @(posedge clk);
         rd(`OFS_STATUS, 32'hc0);
         bus(1'b1, `OFS_CTRL, k ? 32'h20 : 32'h10);
         rd(`OFS_STATUS, 32'h80);
      end
      `CHK(ctrl, 6'h20)
      // the queued break goes out and brings the complete flag back for the receive tests
      tx_busy <= 1'b1;
      @(posedge clk);
      tx_busy <= 1'b0;
      repeat (2) @(posedge clk);
      // all-ones character: idle comes early only when counting starts after the start bit
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, `OFS_CTRL, k ? 32'h0 : 32'h4);
         peer.frame(9'h0ff, 1'b0, 1'b0, 1'b0);
         repeat (12) @(posedge clk);
         rd(`OFS_STATUS, k ? 32'hf0 : 32'he0);
         repeat (60) @(posedge clk);
         rd(`OFS_STATUS, 32'hf0);
         rd_data(8'hff);
         repeat (80) @(posedge clk);
         rd(`OFS_STATUS, 32'hc0);
      end
      rx_case(8'h01, 9'h003, 1'b0, 1'b0, 1'b0, 8'he0);
      rx_case(8'h03, 9'h003, 1'b0, 1'b0, 1'b0, 8'he1);
      rx_case(8'h00, 9'h003, 1'b1, 1'b0, 1'b0, 8'he4);
      rx_case(8'h00, 9'h003, 1'b0, 1'b1, 1'b0, 8'he2);
      rx_case(8'h00, 9'h022, 1'b0, 1'b0, 1'b1, 8'he8);
      rx_case(8'h08, 9'h103, 1'b0, 1'b0, 1'b0, 8'he0);
      finish_test();
   end
endmodule : tb_uart_status_flag_logic
